// [hw/stepper_serial_port.sv]
// Purpose: Serial slave register port of a stepper motor driver.
// Assumes: mclk at 20 MHz, link clock well below mclk/4.
// Notes: Hard clear pin resets all registers like reset_n, except the pin synchroniser flops, which only reset_n clears.
`timescale 1ns/1ps
module stepper_serial_port (
  input wire logic mclk,                       // System clock
  input wire logic reset_n,                    // Synchronous reset, active low
  input wire logic hard_clear,                 // Hard reset pin, active high
  input wire logic select_n,                   // Link select, active low
  input wire logic link_clk,                   // Link serial clock
  input wire logic serial_data_in,             // Link data from master
  output logic serial_data_out,                // Link data to master
  output logic serial_data_out_en,             // High while driving data out
  input wire logic [31:0] status_evt,          // Four event bytes, same clock
  output logic fault_out_n,                    // Fault flag, active low
  input wire logic step_pulse_in,              // Step pulse pin
  output logic step_advance,                   // One-cycle step advance pulse
  input wire logic bemf_sample_strobe,         // Sample moment of coil voltage
  output logic bemf_track,                     // Load-angle stage tracks input
  output logic [2:0] step_resolution,          // Step mode field
  output logic [4:0] peak_current_code,        // Peak current code
  output logic rotation_sense,                 // Direction of rotation
  output logic step_edge_polarity,             // Step edge select
  output logic pwm_rate_double,                // PWM rate doubling
  output logic pwm_dither,                     // PWM dither
  output logic [1:0] slope_rate,               // Slope rate field
  output logic output_stage_enable,            // Output stage enable
  output logic low_power_hold,                 // Low-power hold
  output logic backemf_gain_select,            // Back-EMF gain select
  output logic backemf_pass_through            // Back-EMF pass-through
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  pin_sync_if #(.W(stepper_pkg::PIN_NUM)) pins ();
  // Select enters inverted so the flops' reset value reads as deselected
  assign pins.raw = {hard_clear, step_pulse_in, serial_data_in, link_clk, !select_n};

  pin_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pins(pins)
  );

  wire sel_s = !pins.synced[stepper_pkg::PIN_SEL];  // Back to pin polarity
  wire sclk_s = pins.synced[stepper_pkg::PIN_SCLK];
  wire sdi_s = pins.synced[stepper_pkg::PIN_SDI];
  wire step_s = pins.synced[stepper_pkg::PIN_STEP];
  wire clr_s = pins.synced[stepper_pkg::PIN_CLR];
  wire rst = !reset_n || clr_s;

  // ****************************************************************
  // Edge detection of the sampled link
  // ****************************************************************
  logic sel_d_r;
  logic sclk_d_r;
  logic step_d_r;

  // Delayed copies for edge finding
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
      step_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s;
      sclk_d_r <= sclk_s;
      step_d_r <= step_s;
    end
  end

  wire selected = !sel_s;
  wire sel_rise = sel_s && !sel_d_r;
  wire sclk_rise = sclk_s && !sclk_d_r && selected;
  wire sclk_fall = !sclk_s && sclk_d_r && selected;

  // ****************************************************************
  // Receive side
  // ****************************************************************
  logic [stepper_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [stepper_pkg::BYTE_BITS-1:0] shift_in_r, shift_in_nxt;
  logic [stepper_pkg::ADDR_W-1:0] addr_r;
  logic [stepper_pkg::BYTE_BITS-1:0] wdata_r;
  logic expect_data_r;
  logic wr_ok_r;
  logic clr_pend_r;
  logic long_r;

  // Counter wraps on whole bytes so long polling chains stay byte aligned
  wire cnt_full = (cnt_r == {stepper_pkg::CNT_W{1'b1}});
  assign cnt_nxt = !selected ? '0 :
                   sclk_rise ? cnt_r + 1'b1 : cnt_r;
  // Sticky once the count wraps, so a wrapped count never poses as sixteen
  wire long_nxt = selected && (long_r || (sclk_rise && cnt_full));
  assign shift_in_nxt = !selected ? '0 :
                        sclk_rise ? {shift_in_r[6:0], sdi_s} : shift_in_r;
  wire byte_done = sclk_rise && (cnt_r[2:0] == 3'd7);
  wire [stepper_pkg::BYTE_BITS-1:0] byte_val = {shift_in_r[6:0], sdi_s};
  wire is_write_cmd = byte_val[stepper_pkg::OP_BIT];
  wire [stepper_pkg::ADDR_W-1:0] byte_addr = byte_val[stepper_pkg::ADDR_W-1:0];
  wire byte_is_stat = (byte_addr >= stepper_pkg::ADDR_STAT_BASE) &&
                      (byte_addr < stepper_pkg::ADDR_STAT_BASE + 5'(stepper_pkg::STAT_NUM));

  // Counter and shifter
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
      shift_in_r <= '0;
      long_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      shift_in_r <= shift_in_nxt;
      long_r <= long_nxt;
    end
  end

  // Byte decode; a byte after a read is taken as a command
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_r <= '0;
      wdata_r <= '0;
      expect_data_r <= 1'b0;
      wr_ok_r <= 1'b0;
      clr_pend_r <= 1'b0;
    end else if (!selected) begin
      expect_data_r <= 1'b0;
      wr_ok_r <= 1'b0;
      clr_pend_r <= 1'b0;
    end else if (byte_done && !expect_data_r) begin
      addr_r <= byte_addr;
      expect_data_r <= is_write_cmd;
      wr_ok_r <= 1'b0;
      clr_pend_r <= !is_write_cmd && byte_is_stat;
    end else if (byte_done) begin
      wdata_r <= byte_val;
      expect_data_r <= 1'b0;
      wr_ok_r <= 1'b1;
      clr_pend_r <= 1'b0;
    end else if (sclk_rise) begin
      clr_pend_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [stepper_pkg::BYTE_BITS-1:0] ctrl_r [3];
  // Commit only at select release with exactly sixteen clocks
  // A wrapped count is refused even when its low bits read sixteen
  wire commit = sel_rise && wr_ok_r && !long_r && (cnt_r == 5'(stepper_pkg::PACKET_BITS));
  wire [2:0] ctrl_we;
  assign ctrl_we[0] = commit && (addr_r == stepper_pkg::ADDR_STEP_CUR);
  assign ctrl_we[1] = commit && (addr_r == stepper_pkg::ADDR_DRIVE_OPT);
  assign ctrl_we[2] = commit && (addr_r == stepper_pkg::ADDR_PWR_FB);

  // Other addresses decode no enable, so they stay untouched
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst) begin
        ctrl_r[i] <= stepper_pkg::CTRL_RESET;
      end else if (ctrl_we[i]) begin
        ctrl_r[i] <= wdata_r;
      end
    end
  end

  assign step_resolution = ctrl_r[0][stepper_pkg::STEP_RES_MSB:stepper_pkg::STEP_RES_LSB];
  assign peak_current_code = ctrl_r[0][stepper_pkg::PEAK_CUR_MSB:stepper_pkg::PEAK_CUR_LSB];
  assign rotation_sense = ctrl_r[1][stepper_pkg::ROT_SENSE_BIT];
  assign step_edge_polarity = ctrl_r[1][stepper_pkg::STEP_POL_BIT];
  assign pwm_rate_double = ctrl_r[1][stepper_pkg::PWM_DBL_BIT];
  assign pwm_dither = ctrl_r[1][stepper_pkg::PWM_DITHER_BIT];
  assign slope_rate = ctrl_r[1][stepper_pkg::SLOPE_MSB:stepper_pkg::SLOPE_LSB];
  assign output_stage_enable = ctrl_r[2][stepper_pkg::OUT_EN_BIT];
  assign low_power_hold = ctrl_r[2][stepper_pkg::LP_HOLD_BIT];
  assign backemf_gain_select = ctrl_r[2][stepper_pkg::GAIN_SEL_BIT];
  assign backemf_pass_through = ctrl_r[2][stepper_pkg::PASS_BIT];

  // ****************************************************************
  // Status registers and fault output
  // ****************************************************************
  logic [stepper_pkg::BYTE_BITS-1:0] stat_r [stepper_pkg::STAT_NUM];
  logic [stepper_pkg::BYTE_BITS-1:0] stat_nxt [stepper_pkg::STAT_NUM];
  logic fault_r;
  wire [stepper_pkg::STAT_NUM-1:0] any_evt;

  // Set wins over clear; frozen while a packet is open
  for (genvar g = 0; g < stepper_pkg::STAT_NUM; g++) begin : g_stat
    wire clr = sel_rise && clr_pend_r && (addr_r == stepper_pkg::ADDR_STAT_BASE + 5'(g));
    assign stat_nxt[g] = !sel_s ? stat_r[g] :
                         ((stat_r[g] & {8{!clr}}) | status_evt[g*8 +: 8]);
    assign any_evt[g] = |stat_nxt[g];
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < stepper_pkg::STAT_NUM; i++) begin
      stat_r[i] <= rst ? stepper_pkg::STAT_RESET : stat_nxt[i];
    end
  end

  // Fault follows latched status, held while selected
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (sel_s) begin
      fault_r <= |any_evt;
    end
  end

  assign fault_out_n = !fault_r;

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  logic [stepper_pkg::BYTE_BITS-1:0] shift_out_r;
  logic [stepper_pkg::BYTE_BITS-1:0] rd_data;
  wire addr_is_stat = (addr_r >= stepper_pkg::ADDR_STAT_BASE) &&
                      (addr_r < stepper_pkg::ADDR_STAT_BASE + 5'(stepper_pkg::STAT_NUM));
  wire [1:0] stat_idx = 2'(addr_r - stepper_pkg::ADDR_STAT_BASE);
  wire [stepper_pkg::BYTE_BITS-1:0] stat_sel = stat_r[stat_idx];
  wire stat_par = ^stat_sel[6:0];

  // Read mux; unmapped addresses return zero
  always_comb begin
    rd_data = '0;
    case (addr_r)
      stepper_pkg::ADDR_STEP_CUR: rd_data = ctrl_r[0];
      stepper_pkg::ADDR_DRIVE_OPT: rd_data = ctrl_r[1];
      stepper_pkg::ADDR_PWR_FB: rd_data = ctrl_r[2];
      default: rd_data = addr_is_stat ? {stat_par, stat_sel[6:0]} : '0;
    endcase
  end

  // Reload only after the bytes ending at counts 8, 16 and 24, not at the wrap to 0, so the first byte can be stale
  wire tx_load = sclk_fall && (cnt_r[2:0] == 3'd0) && (cnt_r != '0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_out_r <= '0;
    end else if (tx_load) begin
      shift_out_r <= rd_data;
    end else if (sclk_fall) begin
      shift_out_r <= {shift_out_r[6:0], 1'b0};
    end
  end

  // Slave only: driver enable follows select, never self-started
  assign serial_data_out = shift_out_r[stepper_pkg::BYTE_BITS-1];
  assign serial_data_out_en = selected;

  // ****************************************************************
  // Step edge and load-angle hold
  // ****************************************************************
  logic step_adv_r;
  wire step_edge = step_edge_polarity ? (!step_s && step_d_r) : (step_s && !step_d_r);

  always_ff @(posedge mclk) begin
    if (rst) begin
      step_adv_r <= 1'b0;
    end else begin
      step_adv_r <= step_edge;
    end
  end

  assign step_advance = step_adv_r;
  assign bemf_track = !backemf_pass_through || bemf_sample_strobe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Pin level two edges back is what the synchroniser shows now
  sdo_release_a: assert property ($past(select_n, 2) |-> !serial_data_out_en)
    else $error("data out driven while deselected");
  cnt_clear_a: assert property (sel_s |=> (cnt_r == '0) && (shift_in_r == '0))
    else $error("counter not cleared while deselected");
  write_commit_a: assert property (commit && addr_r == stepper_pkg::ADDR_DRIVE_OPT
    |=> ctrl_r[1] == $past(wdata_r)) else $error("write not committed");
  bad_count_a: assert property (sel_rise && cnt_r != 5'd16 |=> $stable(ctrl_r[0])
    && $stable(ctrl_r[1]) && $stable(ctrl_r[2])) else $error("odd packet wrote");
  ctrl_only_rise_a: assert property (!$stable(ctrl_r[0]) |-> $past(sel_rise))
    else $error("control changed without select release");
  parity_read_a: assert property (addr_is_stat |-> rd_data[7] == ^rd_data[6:0])
    else $error("status parity wrong");
  stat_frozen_a: assert property (!$stable(stat_r[0]) |-> $past(sel_s))
    else $error("status moved while selected");
  fault_frozen_a: assert property (!$stable(fault_r) |-> $past(sel_s))
    else $error("fault moved while selected");
  tx_load_a: assert property (tx_load |=> shift_out_r == $past(rd_data))
    else $error("shift buffer not reloaded");
  step_rise_a: assert property (!step_edge_polarity && step_s && !step_d_r
    |=> step_advance) else $error("rising step edge missed");
  ro_write_a: assert property (commit && addr_is_stat && status_evt == '0
    |=> stat_r[stat_idx] == $past(stat_r[stat_idx])) else $error("status written");

  write_seen_c: cover property (commit);
  clear_seen_c: cover property (sel_rise && clr_pend_r);
  reload_seen_c: cover property (tx_load && addr_is_stat);
  step_seen_c: cover property (step_advance);
  long_seen_c: cover property (sel_rise && long_r);
endmodule : stepper_serial_port

// [pkg/stepper_pkg.sv]
// Purpose: Shared constants for the stepper driver serial register port.
// Assumes: Slave side only; link clock is sampled by mclk.
// Notes: Addresses are 5-bit register numbers carried in the command byte.
package stepper_pkg;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 5;
  localparam int OP_BIT = 7;
  localparam int PACKET_BITS = 16;
  localparam int CNT_W = 5;
  localparam int STAT_NUM = 4;
  localparam int PARITY_BIT = 7;
  localparam logic [ADDR_W-1:0] ADDR_STEP_CUR = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_DRIVE_OPT = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_PWR_FB = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_STAT_BASE = 5'h04;
  localparam logic [BYTE_BITS-1:0] CTRL_RESET = 8'h00;
  localparam logic [BYTE_BITS-1:0] STAT_RESET = 8'h00;
  // Field positions, step_and_current_control
  localparam int STEP_RES_MSB = 7;
  localparam int STEP_RES_LSB = 5;
  localparam int PEAK_CUR_MSB = 4;
  localparam int PEAK_CUR_LSB = 0;
  // Field positions, drive_option_control
  localparam int ROT_SENSE_BIT = 7;
  localparam int STEP_POL_BIT = 6;
  localparam int PWM_DBL_BIT = 3;
  localparam int PWM_DITHER_BIT = 2;
  localparam int SLOPE_MSB = 1;
  localparam int SLOPE_LSB = 0;
  // Field positions, power_and_feedback_control
  localparam int OUT_EN_BIT = 7;
  localparam int LP_HOLD_BIT = 6;
  localparam int GAIN_SEL_BIT = 5;
  localparam int PASS_BIT = 4;
  // Synchronised pin vector order
  localparam int PIN_SEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_STEP = 3;
  localparam int PIN_CLR = 4;
  localparam int PIN_NUM = 5;
endpackage : stepper_pkg

// [pkg/pin_sync_if.sv]
// Purpose: Carries raw pins to the synchroniser and synced levels back.
// Assumes: One bit per pin, all sampled by mclk.
// Notes: Raw bits are read only by the synchroniser.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user (output raw, input synced);
endinterface : pin_sync_if

// [hw/pin_sync.sv]
// Purpose: Two-flop synchroniser for pins outside the mclk domain.
// Assumes: Pins change slowly against mclk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync (
  input wire logic mclk,          // System clock
  input wire logic reset_n,       // Synchronous reset, active low
  pin_sync_if.sync_side pins      // Raw in, synced out
);
  logic [$bits(pins.raw)-1:0] meta_r;
  logic [$bits(pins.raw)-1:0] sync_r;

  // Two stages; first stage may go metastable
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins.raw;
      sync_r <= meta_r;
    end
  end

  assign pins.synced = sync_r;
endmodule : pin_sync

// [verification/serial_master.sv]
// Purpose: Behavioural serial master that drives the register port's link.
// Assumes: Link clock period 400 ns, idle low; select high between packets.
// Notes: A released data line shows the inverse of its last level.
`timescale 1ns/1ps
module serial_master (
  output logic select_n,               // Select, active low
  output logic link_clk,               // Serial clock to device
  output logic serial_data_in,         // Data to device
  input wire logic serial_data_out,    // Data from device
  input wire logic serial_data_out_en, // Device drives data out
  output logic [7:0] last_byte,        // Last full byte received
  output logic done                    // Toggles at each packet end
);
  logic float_lvl;
  wire do_line = serial_data_out_en ? serial_data_out : float_lvl;
  // **********************************************
  // Released line
  // **********************************************
  // No pull resistor, so a sticky last value must not pass for data
  always @(negedge serial_data_out_en) float_lvl = ~serial_data_out;
  initial begin
    select_n = 1'b1;
    link_clk = 1'b0;
    serial_data_in = 1'b0;
    last_byte = 8'h00;
    done = 1'b0;
    float_lvl = 1'b0;
  end
  // One packet of n clocks, bits taken from the top of bits
  task automatic packet(input logic [23:0] bits, input int n);
    logic [7:0] sh;
    sh = 8'h00;
    #13 select_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      serial_data_in = bits[23-i];
      #200 link_clk = 1'b1;
      #50 sh = {sh[6:0], do_line};
      #150 link_clk = 1'b0;
    end
    #400 select_n = 1'b1;
    serial_data_in = ~serial_data_in; // Stale data is not held
    last_byte = sh;
    done = ~done;
    #600;
  endtask : packet
endmodule : serial_master

// [verification/tb.sv]
// Purpose: Self-checking bench for the stepper serial register port.
// Assumes: Master model owns the link pins; bench owns the other inputs.
// Notes: Read results are queued by the driver and checked per packet.
`timescale 1ns/1ps
module tb;
  logic mclk, reset_n, hard_clear, select_n, link_clk, serial_data_in;
  logic serial_data_out, serial_data_out_en, fault_out_n, step_pulse_in, step_advance;
  logic bemf_sample_strobe, bemf_track, rotation_sense, step_edge_polarity, pwm_rate_double;
  logic pwm_dither, output_stage_enable, low_power_hold, backemf_gain_select, backemf_pass_through;
  logic [31:0] status_evt;
  logic [2:0] step_resolution;
  logic [4:0] peak_current_code;
  logic [1:0] slope_rate;
  logic [7:0] last_byte, r1, r2, r3;
  logic pkt_done;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int steps = 0;
  int s0, seed;
  int s0_list[4] = '{8, 15, 17, 24};
  wire [23:0] ctrl = {step_resolution, peak_current_code, rotation_sense, step_edge_polarity, 2'b00,
    pwm_rate_double, pwm_dither, slope_rate, output_stage_enable, low_power_hold,
    backemf_gain_select, backemf_pass_through, 4'h0};
  stepper_serial_port stepper_serial_port_inst (.mclk(mclk), .reset_n(reset_n), .hard_clear(hard_clear),
    .select_n(select_n), .link_clk(link_clk), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en), .status_evt(status_evt),
    .fault_out_n(fault_out_n), .step_pulse_in(step_pulse_in), .step_advance(step_advance),
    .bemf_sample_strobe(bemf_sample_strobe), .bemf_track(bemf_track), .step_resolution(step_resolution),
    .peak_current_code(peak_current_code), .rotation_sense(rotation_sense),
    .step_edge_polarity(step_edge_polarity), .pwm_rate_double(pwm_rate_double), .pwm_dither(pwm_dither),
    .slope_rate(slope_rate), .output_stage_enable(output_stage_enable), .low_power_hold(low_power_hold),
    .backemf_gain_select(backemf_gain_select), .backemf_pass_through(backemf_pass_through));
  serial_master serial_master_inst (.select_n(select_n), .link_clk(link_clk), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en), .last_byte(last_byte),
    .done(pkt_done));
  // **********************************************
  // Clock, counters and helpers
  // **********************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Step pulses counted here so a double pulse is caught
  always @(posedge mclk) if (step_advance === 1'b1) steps <= steps + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] expv);
    comparisons++;
    if (got !== expv) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, expv);
    end
  endtask : chk
  task automatic stop_test;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic pkt(input logic [23:0] b, input int n, input logic care, input logic [7:0] ev);
    exp_q.push_back({care, ev});
    serial_master_inst.packet(b, n);
  endtask : pkt
  // Second byte is a read of address 0, so the first byte's register comes back
  task automatic rd(input logic [7:0] a, input logic [7:0] ev);
    pkt({a, 16'h0000}, 16, 1'b1, ev);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
    pkt({8'h80 | a, d, 8'h00}, n, 1'b0, 8'h00);
  endtask : wr
  // **********************************************
  // Result monitor
  // **********************************************
  // Guarded pop: the master's start-up value change also wakes this process
  always @(pkt_done) begin
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8]) chk(last_byte, e[7:0]);
    end
  end
  initial begin
    #3_000_000;
    error_cnt++;
    stop_test();
  end
  // **********************************************
  // Scenarios
  // **********************************************
  initial begin
    seed = $urandom(32'hac5b);
    {reset_n, hard_clear, step_pulse_in, bemf_sample_strobe} = 4'h0;
    status_evt = 32'h0000_0000;
    tick(8);
    reset_n = 1'b1;
    tick(4);
    chk(serial_data_out_en, 0);
    for (int a = 1; a < 8; a++) rd(a[7:0], 8'h00);
    chk(ctrl, 0);
    r1 = 8'($urandom);
    r2 = 8'($urandom) & 8'hcf;
    r3 = 8'($urandom) & 8'hf0;
    wr(8'h01, r1, 16);
    wr(8'h02, r2, 16);
    wr(8'h03, r3, 16);
    chk(ctrl, {r1, r2, r3});
    rd(8'h01, r1);
    rd(8'h03, r3);
    pkt({8'h01, 8'h02, 8'h03}, 24, 1'b1, r2);
    foreach (s0_list[i]) wr(8'h01, ~r1, s0_list[i]);
    pkt({8'h02, 8'h81, 8'h00}, 16, 1'b0, 8'h00);
    wr(8'h04, 8'h7f, 16);
    chk(ctrl, {r1, r2, r3});
    rd(8'h04, 8'h00);
    tick(1);
    status_evt = 32'h1600_0007;
    tick(1);
    status_evt = 32'h0000_0000;
    tick(6);
    chk(fault_out_n, 0);
    rd(8'h04, 8'h87);
    rd(8'h07, 8'h96);
    pkt({8'h04, 16'h0000}, 8, 1'b0, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h07, 8'h96);
    pkt({8'h07, 16'h0000}, 8, 1'b0, 8'h00);
    tick(6);
    chk(fault_out_n, 1);
    fork
      rd(8'h00, 8'h00);
      begin
        tick(60);
        status_evt = 32'h0000_0100;
        tick(1);
        status_evt = 32'h0000_0000;
      end
    join
    rd(8'h05, 8'h00);
    for (int p = 0; p < 2; p++) begin
      r2[6] = p[0];
      wr(8'h02, r2, 16);
      s0 = steps;
      step_pulse_in = 1'b1;
      tick(8);
      chk(steps - s0, (p == 0) ? 1 : 0);
      step_pulse_in = 1'b0;
      tick(8);
      chk(steps - s0, 1);
    end
    for (int p = 0; p < 2; p++) begin
      r3[4] = p[0];
      wr(8'h03, r3, 16);
      for (int s = 0; s < 2; s++) begin
        bemf_sample_strobe = s[0];
        tick(1);
        chk(bemf_track, (p == 1) ? s[0] : 1'b1);
      end
    end
    hard_clear = 1'b1;
    tick(5);
    hard_clear = 1'b0;
    tick(5);
    chk(ctrl, 0);
    rd(8'h02, 8'h00);
    chk(exp_q.size(), 0);
    stop_test();
  end
endmodule : tb
